//--- shared/ssp_pkg.sv
// constants, command codes and decode helpers for the status protect block
// Functional notes
// - eight-bit status: enable, level, latch, busy
// - reserved bits read ones only while busy
// - bit zero high while busy, else low
// - status read opcode shifts status out
// - latch set opcode then deselect sets latch
// - latch comes up cleared after power-up
// - latch clear opcode ignores protect pin
// - status write changes bits 7, 3, 2 only
// - enable and level bits are nonvolatile
// - during write cycle only status read works
// - finished status write clears the latch
// - write cycle starts at deselect edge
// - level codes none, quarter, half, all
// - quarter level guards top quarter addresses
// - half level guards upper half addresses
// - pin low with enable set blocks status writes
// - array write needs latch and unguarded address
// - enable clear makes protect pin irrelevant
// - hardware protection needs pin low and enable
// - enable cannot clear while pin stays low
// - opcode upper nibble zero, bit three ignored
// - pin falling mid-frame aborts status write
// - unknown opcode silences device until reselect
package ssp_pkg;
  localparam int STAT_W   = 8;
  localparam int BIT_PPE  = 7;
  localparam int RSV_HI   = 6;
  localparam int RSV_LO   = 4;
  localparam int BL_HI    = 3;
  localparam int BL_LO    = 2;
  localparam int BIT_WEL  = 1;
  localparam int BIT_BUSY = 0;
  localparam int NV_W     = 3;

  localparam logic [2:0] OP_LATCH_SET = 3'h6;
  localparam logic [2:0] OP_LATCH_CLR = 3'h4;
  localparam logic [2:0] OP_STAT_RD   = 3'h5;
  localparam logic [2:0] OP_STAT_WR   = 3'h1;
  localparam logic [2:0] OP_ARR_RD    = 3'h3;
  localparam logic [2:0] OP_ARR_WR    = 3'h2;

  localparam logic [4:0] BITS_OPCODE  = 5'h08;
  localparam logic [4:0] BITS_STAT_WR = 5'h10;
  localparam logic [4:0] BIT_CNT_MAX  = 5'h1f;
  localparam logic [4:0] BIT_OP_LAST  = 5'h07;
  localparam logic [4:0] BIT_DAT_LAST = 5'h0f;

  localparam logic [1:0] LVL_NONE    = 2'h0;
  localparam logic [1:0] LVL_QUARTER = 2'h1;
  localparam logic [1:0] LVL_HALF    = 2'h2;
  localparam logic [1:0] LVL_ALL     = 2'h3;

  localparam logic [2:0] NV_RESET   = 3'h0;
  localparam logic [7:0] STAT_RESET = 8'h00;

  localparam int CLK_MHZ = 100;
  localparam int TWC_US  = 5000;
  localparam int TWC_CYC = TWC_US * CLK_MHZ;
  localparam int TMR_W   = 20;

  typedef enum logic [1:0] {
    WS_IDLE  = 2'b01,
    WS_CYCLE = 2'b10
  } ssp_wstate_e;

  function automatic logic opIs(input logic [7:0] op,
                                input logic [2:0] code);
    return (op[7:4] == 4'h0) && (op[2:0] == code);
  endfunction

  function automatic logic opKnown(input logic [7:0] op);
    return opIs(op, OP_LATCH_SET) || opIs(op, OP_LATCH_CLR) ||
           opIs(op, OP_STAT_RD) || opIs(op, OP_STAT_WR) ||
           opIs(op, OP_ARR_RD) || opIs(op, OP_ARR_WR);
  endfunction

  // top address bits pick the guarded fraction of the array
  function automatic logic blockHit(input logic [15:0] addr,
                                    input logic [1:0]  lvl,
                                    input logic        big);
    logic [1:0] hi;
    logic       hit;
    hi = big ? addr[14:13] : addr[13:12];
    case (lvl)
      LVL_QUARTER: hit = (hi == 2'h3);
      LVL_HALF:    hit = hi[1];
      LVL_ALL:     hit = 1'b1;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction
endpackage

//--- logic/ssp_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ssp_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_q <= s3_q;
      end
    end
  end

  assign q = q_q;
endmodule

//--- logic/ssp_nv_bits.sv
// nonvolatile protect enable and level bits
`timescale 1ns/1ps
module ssp_nv_bits
  import ssp_pkg::*;
(
  // clock and factory reset
  input  wire logic                     clk,
  input  wire logic                     nvRstN,
  // write port
  input  wire logic                     latch_set_cmd,
  input  wire logic [ssp_pkg::NV_W-1:0] wrData,
  output logic      [ssp_pkg::NV_W-1:0] nvBits
);
  logic [NV_W-1:0] cell_q;

  // only the factory reset touches these cells, not nrst
  always_ff @(posedge clk or negedge nvRstN) begin
    if (!nvRstN) begin
      cell_q <= NV_RESET;
    end else if (latch_set_cmd) begin
      cell_q <= wrData;
    end
  end

  assign nvBits = cell_q;
endmodule

//--- logic/ssp_status_protect.sv
// status register and write protection of a serial eeprom
`timescale 1ns/1ps
module ssp_status_protect #(
  parameter int WR_CYCLES = ssp_pkg::TWC_CYC
) (
  // system
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       nvRstN,
  // serial link
  input  wire logic                       sck,
  input  wire logic                       csN,
  input  wire logic                       si,
  output logic                            so,
  output logic                            soOe,
  // protect pin and size strap
  input  wire logic                       wpN,
  input  wire logic                       bigArray,
  // array write engine
  input  wire logic                       arrWrReq,
  input  wire logic [15:0]                arrWrAddr,
  input  wire logic                       arrBusy,
  input  wire logic                       arrWrDone,
  output logic                            arrWrOk,
  output logic                            arrWrRefuse,
  // observation
  output logic                            devBusy,
  output logic      [ssp_pkg::STAT_W-1:0] statusView
);
  import ssp_pkg::*;

  // ---------------- link clock domain ----------------
  logic              sckRstN;
  logic [4:0]        bitCnt_q;
  logic [4:0]        bitCnt_d;
  logic [7:0]        shiftIn_q;
  logic [7:0]        byteIn;
  logic              lock_q;
  logic              lock_d;
  logic              rdAct_q;
  logic              rdAct_d;
  logic [7:0]        opCap_q;
  logic [7:0]        dataCap_q;
  logic [4:0]        bitsSeen_q;
  logic              frameTgl_q;
  logic [STAT_W-1:0] statCap_q;
  logic [STAT_W-1:0] statusQ_q;
  logic [STAT_W-1:0] statusSck;
  logic [2:0]        outIdx_q;
  logic              soOut_q;
  logic              soOe_q;
  logic              opDone;
  logic              opBad;
  logic              opRd;
  logic              busySck;

  // deselect clears frame state at once, sck may be stopped
  assign sckRstN  = nrst & ~csN;
  assign byteIn   = {shiftIn_q[6:0], si};
  assign opDone   = (bitCnt_q == BIT_OP_LAST) && !lock_q;
  assign opBad    = !opKnown(byteIn);
  assign opRd     = opIs(byteIn, OP_STAT_RD);
  assign busySck  = statusSck[BIT_BUSY];
  assign bitCnt_d = (bitCnt_q == BIT_CNT_MAX) ? bitCnt_q
                                              : bitCnt_q + 5'h01;
  assign lock_d   = lock_q | (opDone & (opBad | (busySck & ~opRd)));
  assign rdAct_d  = rdAct_q | (opDone & opRd);

  // status word reaches the link side through a synchroniser
  ssp_sync3 #(
    .W (STAT_W)
  ) u_statSync (
    .clk  (sck),
    .rstN (nrst),
    .d    (statusQ_q),
    .q    (statusSck)
  );

  always_ff @(posedge sck or negedge sckRstN) begin
    if (!sckRstN) begin
      bitCnt_q <= 5'h00;
    end else if (!lock_q) begin
      bitCnt_q <= bitCnt_d;
    end
  end

  always_ff @(posedge sck or negedge sckRstN) begin
    if (!sckRstN) begin
      lock_q  <= 1'b0;
      rdAct_q <= 1'b0;
    end else begin
      lock_q  <= lock_d;
      rdAct_q <= rdAct_d;
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      shiftIn_q <= 8'h00;
    end else if (!lock_q) begin
      shiftIn_q <= byteIn;
    end
  end

  // captures stay put after deselect for the system side
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      opCap_q    <= 8'h00;
      dataCap_q  <= 8'h00;
      bitsSeen_q <= 5'h00;
      frameTgl_q <= 1'b0;
    end else if (!lock_q) begin
      bitsSeen_q <= bitCnt_d;
      if (bitCnt_q == 5'h00) begin
        frameTgl_q <= ~frameTgl_q;
      end
      if (bitCnt_q == BIT_OP_LAST) begin
        opCap_q <= byteIn;
      end
      if (bitCnt_q == BIT_DAT_LAST) begin
        dataCap_q <= byteIn;
      end
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      statCap_q <= STAT_RESET;
    end else if (opDone && opRd) begin
      statCap_q <= statusSck;
    end
  end

  // output shifts on falling edges, msb first, repeating
  always_ff @(negedge sck or negedge sckRstN) begin
    if (!sckRstN) begin
      outIdx_q <= 3'h0;
      soOut_q  <= 1'b0;
      soOe_q   <= 1'b0;
    end else begin
      soOe_q <= rdAct_q;
      if (rdAct_q) begin
        soOut_q  <= statCap_q[3'h7 - outIdx_q];
        outIdx_q <= outIdx_q + 3'h1;
      end
    end
  end

  assign so   = soOut_q;
  assign soOe = soOe_q;

  // ---------------- system clock domain ----------------
  logic [2:0]        pinSync;
  logic              csLvl;
  logic              wpLvl;
  logic              tglLvl;
  logic              csPrev_q;
  logic              wpPrev_q;
  logic              tglSeen_q;
  logic              csRise;
  logic              csFall;
  logic              wpFall;
  logic              take;
  logic              abort_q;
  logic              abort_d;
  logic              wel_q;
  logic              wel_d;
  logic              big_q;
  logic              bigSeen_q;
  ssp_wstate_e       wst_q;
  ssp_wstate_e       wst_d;
  logic [TMR_W-1:0]  tmr_q;
  logic [TMR_W-1:0]  tmr_d;
  logic [NV_W-1:0]   pend_q;
  logic [NV_W-1:0]   nvBits;
  logic              ppe;
  logic [1:0]        lvl;
  logic              wrBusy;
  logic              busy;
  logic              hwProt;
  logic              cmdSet;
  logic              cmdClr;
  logic              cmdWr;
  logic              tmrDone;
  logic [STAT_W-1:0] statusD;
  logic              arrHit;
  logic              arrOk_q;
  logic              arrRef_q;
  logic              devBusy_q;

  // frame toggle shares the pin synchroniser with select and pin
  // select and pin enter inverted so reset equals their idle level
  ssp_sync3 #(
    .W (3)
  ) u_pinSync (
    .clk  (mclk),
    .rstN (nrst),
    .d    ({frameTgl_q, ~csN, ~wpN}),
    .q    (pinSync)
  );

  ssp_nv_bits u_nv (
    .clk    (mclk),
    .nvRstN (nvRstN),
    .latch_set_cmd   (tmrDone),
    .wrData (pend_q),
    .nvBits (nvBits)
  );

  assign tglLvl  = pinSync[2];
  assign csLvl   = ~pinSync[1];
  assign wpLvl   = ~pinSync[0];
  assign ppe     = nvBits[2];
  assign lvl     = nvBits[1:0];
  assign csRise  = csLvl & ~csPrev_q;
  assign csFall  = ~csLvl & csPrev_q;
  assign wpFall  = ~wpLvl & wpPrev_q;
  assign take    = csRise & (tglLvl != tglSeen_q);
  assign wrBusy  = (wst_q == WS_CYCLE);
  assign busy    = wrBusy | arrBusy;
  assign hwProt  = ppe & ~wpLvl;
  assign tmrDone = wrBusy && (tmr_q == '0);

  assign cmdSet = take & ~busy & opIs(opCap_q, OP_LATCH_SET) &
                  (bitsSeen_q == BITS_OPCODE);
  assign cmdClr = take & ~busy & opIs(opCap_q, OP_LATCH_CLR) &
                  (bitsSeen_q == BITS_OPCODE);
  assign cmdWr  = take & ~busy & opIs(opCap_q, OP_STAT_WR) &
                  (bitsSeen_q == BITS_STAT_WR) & wel_q &
                  ~hwProt & ~abort_q;

  // set wins over any clear in the same cycle
  assign wel_d = cmdSet ? 1'b1 :
                 (cmdClr | tmrDone | arrWrDone) ? 1'b0 : wel_q;

  assign abort_d = (wpFall & ~csLvl & ppe) ? 1'b1 :
                   csFall ? 1'b0 : abort_q;

  assign statusD = {ppe, {3{busy}}, lvl, wel_q, busy};

  assign arrHit = blockHit(arrWrAddr, lvl, big_q);

  always_comb begin
    wst_d = wst_q;
    tmr_d = tmr_q;
    case (wst_q)
      WS_IDLE: begin
        if (cmdWr) begin
          wst_d = WS_CYCLE;
          tmr_d = TMR_W'(WR_CYCLES - 1);
        end
      end
      WS_CYCLE: begin
        if (tmrDone) begin
          wst_d = WS_IDLE;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      default: begin
        wst_d = WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wst_q <= WS_IDLE;
      tmr_q <= '0;
    end else begin
      wst_q <= wst_d;
      tmr_q <= tmr_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= NV_RESET;
    end else if (cmdWr) begin
      pend_q <= {dataCap_q[BIT_PPE], dataCap_q[BL_HI:BL_LO]};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wel_q <= 1'b0;
    end else begin
      wel_q <= wel_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      csPrev_q  <= 1'b1;
      wpPrev_q  <= 1'b1;
      tglSeen_q <= 1'b0;
      abort_q   <= 1'b0;
    end else begin
      csPrev_q <= csLvl;
      wpPrev_q <= wpLvl;
      abort_q  <= abort_d;
      if (csRise) begin
        tglSeen_q <= tglLvl;
      end
    end
  end

  // size strap caught once after reset release
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      big_q     <= 1'b0;
      bigSeen_q <= 1'b0;
    end else if (!bigSeen_q) begin
      big_q     <= bigArray;
      bigSeen_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      statusQ_q <= STAT_RESET;
      devBusy_q <= 1'b0;
    end else begin
      statusQ_q <= statusD;
      devBusy_q <= busy;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arrOk_q  <= 1'b0;
      arrRef_q <= 1'b0;
    end else begin
      arrOk_q  <= arrWrReq & wel_q & ~arrHit;
      arrRef_q <= arrWrReq & ~(wel_q & ~arrHit);
    end
  end

  assign arrWrOk     = arrOk_q;
  assign arrWrRefuse = arrRef_q;
  assign devBusy     = devBusy_q;
  assign statusView  = statusQ_q;
endmodule

//--- tb/ssp_checker.sv
// port assertions for the status protect block
`timescale 1ns/1ps
module ssp_checker (
  // system
  input wire logic       mclk,
  input wire logic       nrst,
  // link and array check
  input wire logic       csN,
  input wire logic       soOe,
  input wire logic       arrWrReq,
  input wire logic       arrWrOk,
  input wire logic       arrWrRefuse,
  input wire logic [7:0] statusView
);
  logic [1:0] started_q;
  wire  [2:0] nv = {statusView[7], statusView[3:2]};
  // nv bits reappear one edge after reset release, skip that step
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      started_q <= 2'h0;
    end else begin
      started_q <= {started_q[0], 1'b1};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_one; arrWrReq |=> arrWrOk != arrWrRefuse; endproperty
  property p_idle; !arrWrReq |=> !arrWrOk && !arrWrRefuse; endproperty
  // status view lags one edge, so it shows the state the answer used
  property p_wel; arrWrReq ##1 !statusView[1] |-> arrWrRefuse; endproperty
  property p_all; arrWrReq ##1 statusView[3:2] == 2'h3 |-> arrWrRefuse;
  endproperty
  property p_none; arrWrReq ##1 statusView[3:1] == 3'h1 |-> arrWrOk;
  endproperty
  property p_rsv0; !statusView[0] |-> statusView[6:4] == 3'h0; endproperty
  property p_rsv1; statusView[6:4] != 3'h0 |-> statusView[6:4] == 3'h7;
  endproperty
  property p_oe; csN && $past(csN) |-> !soOe; endproperty
  property p_nv;
    started_q[1] && $changed(nv) |-> $past(statusView[0]) ||
                                  $past(statusView[0], 2);
  endproperty
  a_one: assert property (p_one)
    else $error("array answer not exactly one");
  a_idle: assert property (p_idle)
    else $error("array answer without request");
  a_wel: assert property (p_wel)
    else $error("array write allowed without latch");
  a_all: assert property (p_all)
    else $error("array write allowed at full level");
  a_none: assert property (p_none)
    else $error("array write refused at no level");
  a_rsv0: assert property (p_rsv0)
    else $error("reserved bits set while idle");
  a_rsv1: assert property (p_rsv1)
    else $error("reserved bits mixed");
  a_oe: assert property (p_oe)
    else $error("output driven while deselected");
  a_nv: assert property (p_nv)
    else $error("protect bits changed outside a write cycle");
  c_ok: cover property (arrWrOk);
  c_ref: cover property (arrWrRefuse);
  c_done: cover property ($fell(statusView[0]));
endmodule
bind ssp_status_protect ssp_checker ssp_checker_i (.mclk, .nrst, .csN,
  .soOe, .arrWrReq, .arrWrOk, .arrWrRefuse, .statusView);

//--- tb/ssp_spi_master.sv
// spi master model driving the serial link in mode 0
`timescale 1ns/1ps
module ssp_spi_master (
  // link
  output logic      sck,
  output logic      csN,
  output logic      si,
  input  wire logic so
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si  = 1'b1;
  end
  // msb first; so is taken at rising edges after the opcode
  task automatic xfer(input logic [15:0] v, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    #7 csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = v[15-i];
      #16 sck = 1'b1;
      if (i > 7) rd = {rd[6:0], so};
      #16 sck = 1'b0;
    end
    si = ~si;
    #16 csN = 1'b1;
    #80;
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking regression for the status protect block
`timescale 1ns/1ps
module tb_top;
  import ssp_pkg::*;
  localparam int WRC = 200;
  logic        mclk, nrst, nvRstN, wpN, bigArray;
  logic        arrWrReq, arrBusy, arrWrDone;
  logic [15:0] arrWrAddr;
  logic        so, soOe, arrWrOk, arrWrRefuse, devBusy;
  logic [7:0]  statusView, rd;
  wire         sck, csN, si;
  wire         soLine = soOe ? so : ~so;
  int          miscompares, check_count, ppe, lvl, write_enable_latch;

  ssp_status_protect #(.WR_CYCLES(WRC)) ssp_status_protect_i (.mclk,
    .nrst, .nvRstN, .sck, .csN, .si, .so, .soOe, .wpN, .bigArray,
    .arrWrReq, .arrWrAddr, .arrBusy, .arrWrDone, .arrWrOk, .arrWrRefuse,
    .devBusy, .statusView);
  ssp_spi_master ssp_spi_master_i (.sck, .csN, .si, .so(soLine));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mstat(input int b);
    return {ppe[0], {3{b[0]}}, lvl[1:0], write_enable_latch[0], b[0]};
  endfunction
  task automatic waitc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic frame(input logic [15:0] v, input int n);
    ssp_spi_master_i.xfer(v, n, rd);
    waitc(10);
  endtask
  task automatic wrs(input logic [7:0] d, input bit ok);
    int k;
    frame(16'h0600, 8);
    write_enable_latch = 1;
    frame({8'h01, d}, 16);
    if (ok) begin
      chk(statusView, mstat(1));
      frame(16'h0500, 16);
      chk(rd, mstat(1));
      frame(16'h0400, 8);
      chk(statusView, mstat(1));
      k = 0;
      while (statusView[0] !== 1'b0) begin
        waitc(1);
        k++;
        if (k > 400) begin
          miscompares++;
          finish_test();
        end
      end
      ppe = d[7];
      lvl = d[3:2];
      write_enable_latch = 0;
      waitc(2);
    end
    chk(statusView, mstat(0));
  endtask
  task automatic acheck(input logic [15:0] a);
    logic [1:0] h;
    bit         ok;
    arrWrReq = 1'b1;
    arrWrAddr = a;
    waitc(1);
    arrWrReq = 1'b0;
    h = bigArray ? a[14:13] : a[13:12];
    ok = write_enable_latch[0] && !(lvl == 3 || (lvl == 2 && h[1]) || (lvl == 1 && &h));
    chk({6'h0, arrWrOk, arrWrRefuse}, {6'h0, ok, !ok});
    waitc(1);
  endtask
  task automatic alevels;
    for (int l = 0; l < 4; l++) begin
      wrs({1'b0, 3'($urandom), l[1:0], 2'($urandom)}, 1);
      for (int j = 0; j < 4; j++) acheck(16'($urandom));
      frame(16'h0600, 8);
      write_enable_latch = 1;
      acheck(bigArray ? 16'h6000 : 16'h3000);
      acheck(bigArray ? 16'h5fff : 16'h2fff);
      for (int j = 0; j < 6; j++) acheck(16'($urandom));
    end
    $display("test levels done");
  endtask

  initial begin
    {nrst, nvRstN, arrWrReq, arrBusy, arrWrDone, bigArray} = 6'h0;
    wpN = 1'b1;
    arrWrAddr = 16'h0000;
    {ppe, lvl, write_enable_latch} = '0;
    void'($urandom(46877));
    waitc(20);
    {nrst, nvRstN} = 2'h3;
    waitc(5);
    chk(statusView, mstat(0));
    frame(16'h0500, 16);
    chk(rd, mstat(0));
    frame(16'h0e00, 8);
    write_enable_latch = 1;
    chk(statusView, mstat(0));
    wpN = 1'b0;
    frame(16'h0400, 8);
    write_enable_latch = 0;
    chk(statusView, mstat(0));
    wpN = 1'b1;
    frame(16'h0600, 9);
    frame(16'h8600, 8);
    chk(statusView, mstat(0));
    $display("test latch done");
    alevels();
    nrst = 1'b0;
    waitc(3);
    bigArray = 1'b1;
    nrst = 1'b1;
    write_enable_latch = 0;
    waitc(5);
    chk(statusView, mstat(0));
    alevels();
    arrBusy = 1'b1;
    waitc(3);
    chk(statusView, mstat(1));
    chk({7'h0, devBusy}, 8'h01);
    arrBusy = 1'b0;
    arrWrDone = 1'b1;
    waitc(1);
    arrWrDone = 1'b0;
    write_enable_latch = 0;
    waitc(3);
    chk(statusView, mstat(0));
    wrs(8'h80, 1);
    frame(16'h0600, 8);
    write_enable_latch = 1;
    // protect pin pulses low for ten cycles inside the frame, high again before deselect
    fork
      frame(16'h010c, 16);
      begin
        waitc(20);
        wpN = 1'b0;
        waitc(10);
        wpN = 1'b1;
      end
    join
    chk(statusView, mstat(0));
    wpN = 1'b0;
    waitc(5);
    wrs(8'h00, 0);
    acheck(16'($urandom));
    wpN = 1'b1;
    waitc(5);
    wrs(8'h00, 1);
    wpN = 1'b0;
    waitc(5);
    wrs(8'h0c, 1);
    $display("test protect done");
    finish_test();
  end
endmodule
